// >>> sbsd_chk.sv
`timescale 1ns/1ps
module sbsd_chk (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_bus_start,
   input wire logic i_bus_mem,
   input wire logic i_bus_write,
   input wire logic [23:0] i_addr,
   input wire logic [7:0] i_data,
   input wire logic [3:0] i_identity_switch_bank,
   input wire logic [7:0] i_page_switch_bank,
   input wire logic i_fetch_wait_switch,
   input wire logic i_opcode_fetch_cycle,
   input wire logic i_cpu_tick,
   input wire logic o_mem_sel,
   input wire logic [15:0] o_mem_addr,
   input wire logic o_io_sel,
   input wire logic [4:0] o_port_index,
   input wire logic o_serial_sel,
   input wire logic o_bus_rdy,
   input wire logic o_card_selected,
   input wire logic [3:0] o_card_select_latch,
   input wire logic o_cpu_wait
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   wire io40 = i_bus_start && !i_bus_mem && i_addr[15:0] == 16'hfc40;
   wire mc = i_bus_start && i_bus_mem && i_addr[23:16] == i_page_switch_bank;
   property p_latch;
      io40 && i_bus_write |=> o_card_select_latch == $past(i_data[3:0]);
   endproperty
   a_latch: assert property (p_latch)
      else $error("select nibble not captured");
   property p_cs;
      o_card_selected |-> o_card_select_latch == i_identity_switch_bank;
   endproperty
   a_cs: assert property (p_cs)
      else $error("selected without identity match");
   property p_unsel;
      i_bus_start && i_bus_mem && !o_card_selected |=> !o_mem_sel;
   endproperty
   a_unsel: assert property (p_unsel)
      else $error("unselected card claimed memory");
   property p_mem;
      mc && o_card_selected |=> o_mem_sel && o_mem_addr == $past(i_addr[15:0]);
   endproperty
   a_mem: assert property (p_mem)
      else $error("window claim or offset wrong");
   property p_range;
      o_io_sel |-> o_port_index <= 5'h11;
   endproperty
   a_range: assert property (p_range)
      else $error("port index out of range");
   property p_serial;
      o_serial_sel |-> o_io_sel && o_port_index < 5'h10;
   endproperty
   a_serial: assert property (p_serial)
      else $error("serial select outside serial ports");
   property p_ser_claim;
      i_bus_start && !i_bus_mem && o_card_selected &&
         i_addr[15:4] == 12'hfc3 |=> o_io_sel && o_serial_sel;
   endproperty
   a_ser_claim: assert property (p_ser_claim)
      else $error("selected card missed a serial port");
   property p_rdy;
      io40 |-> !o_bus_rdy;
   endproperty
   a_rdy: assert property (p_rdy)
      else $error("no wait on select port access");
   property p_fetch;
      $rose(i_opcode_fetch_cycle) && !i_fetch_wait_switch && !o_cpu_wait
         |=> o_cpu_wait;
   endproperty
   a_fetch: assert property (p_fetch)
      else $error("fetch wait missing");
   property p_off;
      i_fetch_wait_switch && !o_cpu_wait |=> !o_cpu_wait;
   endproperty
   a_off: assert property (p_off)
      else $error("fetch wait while disabled");
   property p_one;
      o_cpu_wait && i_cpu_tick |=> !o_cpu_wait;
   endproperty
   a_one: assert property (p_one)
      else $error("fetch wait longer than one state");
   c_sel: cover property (o_card_selected);
   c_mem: cover property (o_mem_sel);
   c_wait: cover property (o_cpu_wait);
endmodule : sbsd_chk

bind sbsd_top sbsd_chk u_chk (.*);

// >>> sbsd_defs.svh
`ifndef SBSD_DEFS_SVH
`define SBSD_DEFS_SVH

// ==========================================================
// host i/o port map
`define SBSD_PORT_LO 16'hfc30
`define SBSD_SERIAL_HI 16'hfc3f
`define SBSD_SEL_PORT 16'hfc40
`define SBSD_PORT_HI 16'hfc41

// ==========================================================
// field positions and widths
`define SBSD_PAGE_MSB 23
`define SBSD_PAGE_LSB 16
`define SBSD_NIB_MSB 3
`define SBSD_NIB_LSB 0

// ==========================================================
// reset values
`define SBSD_SEL_RESET 4'h0
`define SBSD_SELV_RESET 1'b0

// ==========================================================
// wait-state counts, in backplane clock periods; the fetch wait in processor periods
`define SBSD_WAIT_ONE 2'h1
`define SBSD_WAIT_TWO 2'h2
`define SBSD_WAIT_THREE 2'h3
`define SBSD_FETCH_WAITS 1

`endif

// >>> sbsd_host.sv
`timescale 1ns/1ps
module sbsd_host (
   input wire logic i_clk,
   input wire logic o_bus_rdy,
   output logic i_bus_tick,
   output logic i_bus_start,
   output logic i_bus_end,
   output logic i_bus_mem,
   output logic i_bus_write,
   output logic [23:0] i_addr,
   output logic [7:0] i_data
);
   logic [1:0] ph = 2'h0;
   // transfers whose ready never came back; the bench counts them as failures
   int timeouts = 0;
   initial begin
      i_bus_start = 0;
      i_bus_end = 0;
      i_bus_mem = 0;
      i_bus_write = 0;
      i_addr = 24'h0;
      i_data = 8'h0;
   end
   // backplane clock: one tick every four fast cycles
   always @(posedge i_clk) begin
      #1 ph = ph + 2'h1;
      i_bus_tick = (ph == 2'h0);
   end
   // 20-bit masters keep a23..a20 low, so they reach pages below 10h
   task automatic xfer(input logic m, w, input logic [23:0] a,
                       input logic [7:0] d, output int n);
      n = 0;
      @(posedge i_clk);
      #1 i_bus_start = 1;
      i_bus_mem = m;
      i_bus_write = w;
      i_addr = a;
      i_data = d;
      @(posedge i_clk);
      #1 i_bus_start = 0;
      // counts ticks taken while waiting; a hang runs out after 64 fast cycles
      for (int k = 0; k < 64 && !o_bus_rdy; k++) begin
         @(posedge i_clk);
         n += i_bus_tick;
         #1;
      end
      if (!o_bus_rdy) begin
         timeouts++;
      end
      i_bus_end = 1;
      @(posedge i_clk);
      #1 i_bus_end = 0;
      // released lines show garbage, never the last value
      i_addr = ~a;
      i_data = ~d;
   endtask : xfer
endmodule : sbsd_host

// >>> sbsd_pkg.sv
package sbsd_pkg;
   // jumper position for host wait states
   typedef enum logic [1:0] {
      SBSD_HW_A,
      SBSD_HW_B,
      SBSD_HW_C,
      SBSD_HW_NONE
   } sbsd_host_wait_t;

   typedef enum logic [1:0] {
      SBSD_FW_IDLE,
      SBSD_FW_WAIT,
      SBSD_FW_HOLD
   } sbsd_fetch_state_t;
endpackage : sbsd_pkg

// >>> sbsd_top.sv
`timescale 1ns/1ps
`include "sbsd_defs.svh"
// Behaviour
// - switch on reads as 0, switch off reads as 1.
// - card identity is four switch bits, D3 down to D0.
// - decode eighteen shared host i/o ports fc30h to fc41h.
// - host write to fc40h captures low nibble, compared with identity.
// - unselected card ignores serial ports and memory window.
// - eight page switches match a23 down to a16 for the window.
// - page must suit master width: 256 pages at 24 bits, 16 at 20.
// - 256k card still shows only a 64k window to the host.
// - enabled switch adds a wait to every on-board opcode fetch.
// - the opcode-fetch wait lasts exactly one wait state.
// - host accesses get one, two or three waits; two by default.
module sbsd_top
   import sbsd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_bus_tick,
   input wire logic i_cpu_tick,
   input wire logic i_bus_start,
   input wire logic i_bus_end,
   input wire logic i_bus_mem,
   input wire logic i_bus_write,
   input wire logic [23:0] i_addr,
   input wire logic [7:0] i_data,
   input wire logic [3:0] i_identity_switch_bank,
   input wire logic [7:0] i_page_switch_bank,
   input wire logic i_fetch_wait_switch,
   input wire sbsd_pkg::sbsd_host_wait_t i_host_wait_count_setting,
   input wire logic i_opcode_fetch_cycle,
   output logic o_mem_sel,
   output logic [15:0] o_mem_addr,
   output logic o_io_sel,
   output logic [4:0] o_port_index,
   output logic o_serial_sel,
   output logic o_bus_rdy,
   output logic o_card_selected,
   output logic [3:0] o_card_select_latch,
   output logic o_cpu_wait
);
   import sbsd_pkg::*;

   // ==========================================================
   // switch reading
   logic [3:0] card_id;
   logic [7:0] page_id;
   logic fetch_wait_en;

   // paddle on pulls low, so the raw bank already is the value
   assign card_id = i_identity_switch_bank;
   assign page_id = i_page_switch_bank;
   assign fetch_wait_en = ~i_fetch_wait_switch;

   // ==========================================================
   // address decode
   logic [15:0] io_addr;
   logic in_port_range;
   logic is_serial_port;
   logic is_sel_port;
   logic page_hit;
   logic sel_match;
   logic [15:0] port_off;

   assign io_addr = i_addr[15:0];
   assign in_port_range = (io_addr >= `SBSD_PORT_LO) &&
                          (io_addr <= `SBSD_PORT_HI);
   assign is_serial_port = in_port_range &&
                           (io_addr <= `SBSD_SERIAL_HI);
   assign is_sel_port = (io_addr == `SBSD_SEL_PORT);
   assign port_off = io_addr - `SBSD_PORT_LO;
   // a 20-bit master drives a23..a20 low, so only 16 pages reach it
   assign page_hit =
      (i_addr[`SBSD_PAGE_MSB:`SBSD_PAGE_LSB] == page_id);

   // ==========================================================
   // card select latch
   logic [3:0] sel_q;
   logic [3:0] sel_d;
   logic sel_valid_q;
   logic sel_valid_d;
   logic sel_write;

   assign sel_write = i_bus_start && !i_bus_mem && i_bus_write &&
                      is_sel_port;
   assign sel_d = sel_write ? i_data[`SBSD_NIB_MSB:`SBSD_NIB_LSB] :
                  sel_q;
   assign sel_valid_d = sel_valid_q || sel_write;
   assign sel_match = sel_valid_q && (sel_q == card_id);

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sel_q <= `SBSD_SEL_RESET;
         sel_valid_q <= `SBSD_SELV_RESET;
      end else begin
         sel_q <= sel_d;
         sel_valid_q <= sel_valid_d;
      end
   end

   // ==========================================================
   // cycle claim
   // the select port answers on every card so that the host can
   // always change the selection; the rest needs a match
   logic claim_mem;
   logic claim_io;
   logic claim_serial;
   logic mem_sel_q;
   logic mem_sel_d;
   logic io_sel_q;
   logic io_sel_d;
   logic serial_sel_q;
   logic serial_sel_d;
   logic [15:0] mem_addr_q;
   logic [15:0] mem_addr_d;
   logic [4:0] port_idx_q;
   logic [4:0] port_idx_d;

   assign claim_mem = i_bus_start && i_bus_mem && page_hit &&
                      sel_match;
   assign claim_io = i_bus_start && !i_bus_mem && in_port_range &&
                     (is_sel_port || sel_match);
   assign claim_serial = claim_io && is_serial_port &&
                         sel_match;

   assign mem_sel_d = claim_mem ? 1'b1 :
                      i_bus_end ? 1'b0 : mem_sel_q;
   assign io_sel_d = claim_io ? 1'b1 :
                     i_bus_end ? 1'b0 : io_sel_q;
   assign serial_sel_d = claim_serial ? 1'b1 :
                         i_bus_end ? 1'b0 : serial_sel_q;
   // only 64k is offered whatever the fitted memory size
   assign mem_addr_d = claim_mem ? i_addr[15:0] : mem_addr_q;
   assign port_idx_d = claim_io ? port_off[4:0] : port_idx_q;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mem_sel_q <= 1'b0;
         io_sel_q <= 1'b0;
         serial_sel_q <= 1'b0;
         mem_addr_q <= 16'h0000;
         port_idx_q <= 5'h00;
      end else begin
         mem_sel_q <= mem_sel_d;
         io_sel_q <= io_sel_d;
         serial_sel_q <= serial_sel_d;
         mem_addr_q <= mem_addr_d;
         port_idx_q <= port_idx_d;
      end
   end

   // ==========================================================
   // host wait states
   sbsd_wait_if hw ();
   logic [1:0] host_waits;

   assign host_waits =
      (i_host_wait_count_setting == SBSD_HW_A) ? `SBSD_WAIT_ONE :
      (i_host_wait_count_setting == SBSD_HW_C) ? `SBSD_WAIT_THREE :
      `SBSD_WAIT_TWO;
   assign hw.start = claim_mem || claim_io;
   assign hw.count = host_waits;

   sbsd_wait_gen u_host_wait (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_bus_tick(i_bus_tick),
      .w(hw)
   );

   // ready drops in the claim cycle itself so no edge is missed
   assign o_bus_rdy = !(hw.start || hw.busy);

   // ==========================================================
   // on-board opcode fetch wait
   sbsd_fetch_state_t fstate_q;
   sbsd_fetch_state_t fstate_d;
   logic fetch_q;
   logic fetch_rise;

   assign fetch_rise = i_opcode_fetch_cycle && !fetch_q;

   always_comb begin
      fstate_d = fstate_q;
      case (fstate_q)
         SBSD_FW_IDLE: begin
            if (fetch_rise && fetch_wait_en) begin
               fstate_d = SBSD_FW_WAIT;
            end
         end
         SBSD_FW_WAIT: begin
            // one processor period, then release
            if (i_cpu_tick) begin
               fstate_d = SBSD_FW_HOLD;
            end
         end
         SBSD_FW_HOLD: begin
            if (!i_opcode_fetch_cycle) begin
               fstate_d = SBSD_FW_IDLE;
            end
         end
         default: begin
            fstate_d = SBSD_FW_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fstate_q <= SBSD_FW_IDLE;
         fetch_q <= 1'b0;
      end else begin
         fstate_q <= fstate_d;
         fetch_q <= i_opcode_fetch_cycle;
      end
   end

   assign o_cpu_wait = (fstate_q == SBSD_FW_WAIT);

   // ==========================================================
   // outputs
   assign o_mem_sel = mem_sel_q;
   assign o_mem_addr = mem_addr_q;
   assign o_io_sel = io_sel_q;
   assign o_serial_sel = serial_sel_q;
   assign o_port_index = port_idx_q;
   assign o_card_selected = sel_match;
   assign o_card_select_latch = sel_q;
endmodule : sbsd_top

// >>> sbsd_wait_gen.sv
`timescale 1ns/1ps
`include "sbsd_defs.svh"
module sbsd_wait_gen (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_bus_tick,
   sbsd_wait_if.gen w
);
   logic [1:0] left_q;
   logic [1:0] left_d;
   logic tick_dec;

   // ==========================================================
   // countdown of backplane periods
   assign tick_dec = i_bus_tick && (left_q != 2'h0);
   assign left_d = w.start ? w.count :
                   tick_dec ? left_q - 2'h1 : left_q;
   assign w.busy = (left_q != 2'h0);

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         left_q <= 2'h0;
      end else begin
         left_q <= left_d;
      end
   end
endmodule : sbsd_wait_gen

// >>> sbsd_wait_if.sv
`timescale 1ns/1ps
interface sbsd_wait_if;
   logic start;
   logic [1:0] count;
   logic busy;

   modport ctl (output start, output count, input busy);
   modport gen (input start, input count, output busy);
endinterface : sbsd_wait_if

// >>> tb.sv
`timescale 1ns/1ps
module tb;
   import sbsd_pkg::*;
   logic i_clk, i_rst_b, i_bus_tick, i_cpu_tick, i_bus_start, i_bus_end;
   logic i_bus_mem, i_bus_write, i_fetch_wait_switch, i_opcode_fetch_cycle;
   logic [23:0] i_addr;
   logic [7:0] i_data, i_page_switch_bank;
   logic [3:0] i_identity_switch_bank, o_card_select_latch;
   sbsd_host_wait_t i_host_wait_count_setting;
   logic o_mem_sel, o_io_sel, o_serial_sel, o_bus_rdy, o_card_selected;
   logic o_cpu_wait;
   logic [15:0] o_mem_addr;
   logic [4:0] o_port_index;
   int failures = 0, check_count = 0, n;
   sbsd_top DUT (.*);
   sbsd_host host (.*);
   initial begin
      i_clk = 0;
      forever #2 i_clk = ~i_clk;
   end
   task automatic chk(input string s, input logic [15:0] e, g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic close_out;
      failures += host.timeouts;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task automatic t_select;
      chk("latch", 16'h0000, 16'(o_card_select_latch));
      chk("sel", 16'h0000, 16'(o_card_selected));
      host.xfer(0, 1, 24'h00fc40, 8'ha3, n);
      chk("sel port waits", 16'h0002, 16'(n));
      chk("latch", 16'h0003, 16'(o_card_select_latch));
      chk("sel", 16'h0000, 16'(o_card_selected));
      host.xfer(1, 0, 24'h0e0010, 8'h00, n);
      chk("mem waits", 16'h0000, 16'(n));
      host.xfer(0, 0, 24'h00fc31, 8'h00, n);
      chk("serial waits", 16'h0000, 16'(n));
      host.xfer(0, 1, 24'h00fc40, 8'hf5, n);
      chk("sel", 16'h0001, 16'(o_card_selected));
   endtask : t_select
   task automatic t_waits;
      int w[4] = '{1, 2, 3, 2};
      for (int i = 0; i < 4; i++) begin
         i_host_wait_count_setting = sbsd_host_wait_t'(i);
         host.xfer(1, i[0], {16'h0e12, 8'(i)}, 8'h00, n);
         chk("host waits", 16'(w[i]), 16'(n));
         chk("mem addr", {8'h12, 8'(i)}, o_mem_addr);
         chk("mem sel end", 16'h0000, 16'(o_mem_sel));
      end
      host.xfer(1, 0, 24'h0f0000, 8'h00, n);
      chk("other page", 16'h0000, 16'(n));
      host.xfer(0, 0, 24'h00fc41, 8'h00, n);
      chk("port idx", 16'h0011, 16'(o_port_index));
      host.xfer(0, 0, 24'h00fc30, 8'h00, n);
      chk("port idx", 16'h0000, 16'(o_port_index));
      host.xfer(0, 0, 24'h00fc42, 8'h00, n);
      chk("beyond", 16'h0000, 16'(n));
      chk("latch held", 16'h0005, 16'(o_card_select_latch));
   endtask : t_waits
   task automatic t_fetch;
      i_fetch_wait_switch = 0;
      i_opcode_fetch_cycle = 1;
      @(posedge i_clk);
      #1 chk("cpu wait", 16'h0001, 16'(o_cpu_wait));
      @(posedge i_clk);
      #1 chk("wait holds", 16'h0001, 16'(o_cpu_wait));
      i_cpu_tick = 1;
      @(posedge i_clk);
      #1 i_cpu_tick = 0;
      chk("cpu wait", 16'h0000, 16'(o_cpu_wait));
      @(posedge i_clk);
      #1 chk("one per fetch", 16'h0000, 16'(o_cpu_wait));
      i_opcode_fetch_cycle = 0;
      i_fetch_wait_switch = 1;
      @(posedge i_clk);
      #1 i_opcode_fetch_cycle = 1;
      @(posedge i_clk);
      #1 chk("disabled", 16'h0000, 16'(o_cpu_wait));
   endtask : t_fetch
   // reset in mid-run must forget the selection made before it
   task automatic t_reset;
      i_rst_b = 0;
      @(posedge i_clk);
      #1 chk("rst latch", 16'h0000, 16'(o_card_select_latch));
      chk("rst sel", 16'h0000, 16'(o_card_selected));
      chk("rst rdy", 16'h0001, 16'(o_bus_rdy));
      i_rst_b = 1;
      host.xfer(1, 0, 24'h0e0000, 8'h00, n);
      chk("rst mem waits", 16'h0000, 16'(n));
      host.xfer(0, 1, 24'h00fc40, 8'h05, n);
      chk("reselect", 16'h0001, 16'(o_card_selected));
   endtask : t_reset
   initial begin
      i_rst_b = 0;
      i_cpu_tick = 0;
      i_opcode_fetch_cycle = 0;
      i_fetch_wait_switch = 1;
      // raw switches: d3 on, d2 off, d1 on, d0 off gives card 5
      i_identity_switch_bank = 4'h5;
      i_page_switch_bank = 8'h0e;
      i_host_wait_count_setting = SBSD_HW_B;
      repeat (10) @(posedge i_clk);
      #1 i_rst_b = 1;
      t_select();
      t_waits();
      t_fetch();
      t_reset();
      close_out();
   end
endmodule : tb
